// ---- common/sae_pkg.sv ----
// shared constants and types for the setpoint alarm evaluator
package sae_pkg;
    localparam int unsigned        NUM_SP       = 4;
    localparam int unsigned        SP_W         = 24;
    localparam int unsigned        DB_W         = 14;
    localparam int unsigned        DLY_W        = 10;
    localparam int unsigned        OS_W         = 14;
    localparam int unsigned        TYPE_W       = 4;
    localparam int unsigned        ADDR_W       = 8;
    // setpoint limits in hundredths: -999.99 .. 9999.99
    localparam logic signed [23:0] SP_MIN       = -24'sd99999;
    localparam logic signed [23:0] SP_MAX       = 24'sd999999;
    // register byte offsets
    localparam logic [7:0]         OFF_CTRL     = 8'h00;
    localparam logic [7:0]         OFF_STATUS   = 8'h04;
    localparam logic [7:0]         OFF_RANGE_LO = 8'h08;
    localparam logic [7:0]         OFF_RANGE_HI = 8'h0C;
    localparam logic [7:0]         OFF_SP_BASE  = 8'h10;
    localparam logic [7:0]         SP_STRIDE    = 8'h10;
    // word within a setpoint block
    localparam logic [1:0]         SUB_VALUE    = 2'h0;
    localparam logic [1:0]         SUB_CFG      = 2'h1;
    localparam logic [1:0]         SUB_DLY      = 2'h2;
    localparam logic [1:0]         SUB_OS       = 2'h3;
    // control register fields
    localparam int unsigned        CTRL_ZONE    = 0;
    localparam int unsigned        CTRL_COLOUR  = 1;
    localparam int unsigned        CTRL_EVENT   = 2;
    localparam int unsigned        CTRL_TYPE_LO = 4;
    // setpoint value / config / delay fields
    localparam int unsigned        VAL_VALID    = 31;
    localparam int unsigned        CFG_HIGH     = 16;
    localparam int unsigned        CFG_DEEN     = 17;
    localparam int unsigned        DLY_OFF_LO   = 16;
    // status fields
    localparam int unsigned        ST_BAND      = 4;
    localparam int unsigned        ST_COIL_LO   = 8;
    localparam int unsigned        ST_UNCONF    = 12;
    // reset values
    localparam logic [3:0]         DIR_RESET    = 4'hC;
    localparam logic [DB_W-1:0]    DB_RESET     = 14'h0001;
    // 100 ms timer tick
    localparam int unsigned        TICK_MS      = 100;
    localparam int unsigned        CLK_HZ       = 25000000;
    localparam int unsigned        TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;

    typedef enum logic [1:0] {
        SAE_IDLE     = 2'b00,
        SAE_ON_WAIT  = 2'b01,
        SAE_ACTIVE   = 2'b10,
        SAE_OFF_WAIT = 2'b11
    } sae_state_type;
endpackage : sae_pkg

// ---- verilog/sae_evaluator.sv ----
// setpoint alarm evaluator with apb configuration slave
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// (R01) indicator needs value, deadband and on-delay
// (R02) in-band when no alarm indicator lit
// (R03) in-band off in suppression periods
// (R04) delays running keep in-band lit
// (R05) high trip starts on delay, then alarms
// (R06) condition lost early resets on delay
// (R07) falling below starts off delay
// (R08) condition back during off delay keeps alarm
// (R09) zone pattern ignores trip direction
// (R10) in-band equals all alarms inactive region
// (R11) normal pattern uses per-setpoint direction
// (R12) indicator fixed to its own setpoint
// (R13) one-shot pulses, indicator follows value and pulse (value only in event mode)
// (R14) short excursion still gives full pulse
// (R15) event mode pulses on each sample_input_a input
// (R16) per-output coil polarity
// (R17) indicators independent of output settings
// (R18) input type change invalidates setpoints
// (R19) invalid setpoint kills adjoining zones
// (R20) setpoint outside input range never alarms
// (R21) pattern resets to normal
// (R22) colour selectable green-red or red-green
// (R23) deadband holds alarm past setpoint
// (R24) delay counts are 100 ms units
// (R25) one-shot zero means continuous output
// (R26) one-shot overrides off delay
// (R27) evaluate on strobe, time on tick
// (R28) reset clears timers and alarms
module sae_evaluator
    import sae_pkg::*;
#(
    parameter int unsigned TICK_COUNT = TICK_CYCLES
) (
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [ADDR_W-1:0]       paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic signed [SP_W-1:0]  disp_value,
    input  wire logic                    disp_strobe,
    input  wire logic                    sample_input_a,
    input  wire logic                    no_measure,
    input  wire logic                    power_on_delay,
    input  wire logic                    standby,
    output logic      [NUM_SP-1:0]       trip_ind,
    output logic                         in_band,
    output logic      [NUM_SP-1:0]       coil,
    output logic                         colour_red
);

    ////////////////////////////////////////////////////////////////
    // configuration storage
    logic                  pat_zone;
    logic                  colour_sel;
    logic                  event_mode;
    logic [TYPE_W-1:0]     input_type;
    logic signed [SP_W-1:0] range_lo;
    logic signed [SP_W-1:0] range_hi;
    logic signed [SP_W-1:0] sp     [NUM_SP];
    logic [NUM_SP-1:0]     sp_valid;
    logic [DB_W-1:0]       db     [NUM_SP];
    logic [NUM_SP-1:0]     dir_high;
    logic [NUM_SP-1:0]     de_energize;
    logic [DLY_W-1:0]      on_dly [NUM_SP];
    logic [DLY_W-1:0]      off_dly[NUM_SP];
    logic [OS_W-1:0]       os_time[NUM_SP];

    // evaluation state
    sae_state_type         st     [NUM_SP];
    logic [DLY_W-1:0]      dcnt   [NUM_SP];
    logic [OS_W-1:0]       os_cnt [NUM_SP];
    logic [NUM_SP-1:0]     cond;
    logic [NUM_SP-1:0]     next_cond;
    logic [NUM_SP-1:0]     eff_valid;
    logic [NUM_SP-1:0]     ind_c;
    logic [NUM_SP-1:0]     alarm_c;
    logic                  unconf;
    logic                  suppress;
    logic                  zone_ok;
    logic                  samp_s1;
    logic                  samp_s2;
    logic                  samp_s3;
    logic                  eval;
    logic                  eval_d;
    logic [21:0]           tick_cnt;
    logic                  tick;

    ////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic sae_is_sp(input logic [ADDR_W-1:0] a, output int unsigned idx);
        idx = 32'(a - OFF_SP_BASE) / 32'(SP_STRIDE);
        return (a >= OFF_SP_BASE) && (idx < NUM_SP);
    endfunction : sae_is_sp

    function automatic logic signed [SP_W-1:0] sae_db(input logic [DB_W-1:0] d);
        return signed'({{(SP_W-DB_W){1'b0}}, d});
    endfunction : sae_db
    // one spare tick: the first tick may fall right after the timer starts
    function automatic logic sae_elapsed(input logic [DLY_W-1:0] cnt, input logic [DLY_W-1:0] dly);
        return (dly == '0) || (cnt > dly);
    endfunction : sae_elapsed

    ////////////////////////////////////////////////////////////////
    // apb slave: zero wait states
    logic        wr_en;
    logic        rd_en;
    logic        hit_sp;
    int unsigned sidx;
    logic [1:0]  sub;
    logic        mapped;

    assign pready = 1'b1;
    assign wr_en  = psel && penable && pwrite;
    // reads latch in the setup cycle so the data already stands at the access edge
    assign rd_en  = psel && !penable && !pwrite;
    assign sub    = paddr[3:2];

    always_comb begin
        hit_sp = sae_is_sp(paddr, sidx);
        mapped = (paddr[1:0] == 2'h0) && (hit_sp || paddr < OFF_SP_BASE);
    end

    assign pslverr = psel && penable && !mapped;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            pat_zone   <= 1'b0; // R21
            colour_sel <= 1'b0;
            event_mode <= 1'b0;
            input_type <= '0;
            range_lo   <= SP_MIN;
            range_hi   <= SP_MAX;
            sp_valid   <= '0;
            dir_high   <= DIR_RESET;
            de_energize <= '0;
            for (int i = 0; i < NUM_SP; i++) begin
                sp[i]      <= '0;
                db[i]      <= DB_RESET;
                on_dly[i]  <= '0;
                off_dly[i] <= '0;
                os_time[i] <= '0;
            end
        end else if (wr_en && mapped) begin
            if (paddr == OFF_CTRL) begin
                pat_zone   <= pwdata[CTRL_ZONE];
                colour_sel <= pwdata[CTRL_COLOUR];
                event_mode <= pwdata[CTRL_EVENT];
                input_type <= pwdata[CTRL_TYPE_LO +: TYPE_W];
                if (pwdata[CTRL_TYPE_LO +: TYPE_W] != input_type)
                    sp_valid <= '0; // R18
            end
            if (paddr == OFF_RANGE_LO)
                range_lo <= pwdata[SP_W-1:0];
            if (paddr == OFF_RANGE_HI)
                range_hi <= pwdata[SP_W-1:0];
            if (hit_sp) begin
                case (sub)
                    SUB_VALUE: begin
                        // out-of-span values are refused, old setpoint kept
                        if (signed'(pwdata[SP_W-1:0]) >= SP_MIN && signed'(pwdata[SP_W-1:0]) <= SP_MAX) begin
                            sp[sidx]       <= pwdata[SP_W-1:0];
                            sp_valid[sidx] <= pwdata[VAL_VALID];
                        end
                    end
                    SUB_CFG: begin
                        db[sidx]          <= pwdata[DB_W-1:0];
                        dir_high[sidx]    <= pwdata[CFG_HIGH];
                        de_energize[sidx] <= pwdata[CFG_DEEN];
                    end
                    SUB_DLY: begin
                        on_dly[sidx]  <= pwdata[DLY_W-1:0]; // R24
                        off_dly[sidx] <= pwdata[DLY_OFF_LO +: DLY_W];
                    end
                    SUB_OS: os_time[sidx] <= pwdata[OS_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            prdata <= '0;
        end else if (rd_en) begin
            prdata <= '0;
            if (paddr == OFF_CTRL)
                prdata <= 32'({input_type, 1'b0, event_mode, colour_sel, pat_zone});
            if (paddr == OFF_STATUS)
                prdata <= 32'({unconf, coil, 3'h0, in_band, trip_ind});
            if (paddr == OFF_RANGE_LO)
                prdata <= 32'(unsigned'(range_lo));
            if (paddr == OFF_RANGE_HI)
                prdata <= 32'(unsigned'(range_hi));
            if (hit_sp) begin
                case (sub)
                    SUB_VALUE: prdata <= {sp_valid[sidx], 7'h0, sp[sidx]};
                    SUB_CFG:   prdata <= 32'({de_energize[sidx], dir_high[sidx], 2'h0, db[sidx]});
                    SUB_DLY:   prdata <= 32'({6'h0, off_dly[sidx], 6'h0, on_dly[sidx]});
                    SUB_OS:    prdata <= 32'(os_time[sidx]);
                    default:   prdata <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // sample_input_a input synchroniser and 100 ms tick
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            samp_s1 <= 1'b0;
            samp_s2 <= 1'b0;
            samp_s3 <= 1'b0;
        end else begin
            samp_s1 <= sample_input_a;
            samp_s2 <= samp_s1;
            samp_s3 <= samp_s2;
        end
    end

    // outside normal trigger mode only the sample_input_a input samples
    assign eval = event_mode ? (samp_s2 && !samp_s3) : disp_strobe; // R27

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tick_cnt <= '0;
            tick     <= 1'b0;
        end else begin
            tick     <= (tick_cnt == 22'(TICK_COUNT - 1));
            tick_cnt <= (tick_cnt == 22'(TICK_COUNT - 1)) ? '0 : tick_cnt + 22'h1; // R24
        end
    end

    ////////////////////////////////////////////////////////////////
    // trip conditions
    always_comb begin
        for (int i = 0; i < NUM_SP; i++) begin
            eff_valid[i] = sp_valid[i] && sp[i] >= range_lo && sp[i] <= range_hi; // R20
            ind_c[i]     = (st[i] == SAE_ACTIVE) || (st[i] == SAE_OFF_WAIT);
            if (dir_high[i]) // R11
                next_cond[i] = ind_c[i] ? disp_value >= sp[i] - sae_db(db[i]) : disp_value > sp[i]; // R23
            else
                next_cond[i] = ind_c[i] ? disp_value <= sp[i] + sae_db(db[i]) : disp_value < sp[i]; // R23
            next_cond[i] = next_cond[i] && eff_valid[i];
        end
        if (pat_zone) begin
            // zones below, between and above the setpoints, direction unused
            next_cond[0] = eff_valid[0] && disp_value < sp[0]; // R09 R19
            next_cond[1] = &eff_valid[1:0] && disp_value >= sp[0] && disp_value < sp[1]; // R09 R19
            next_cond[2] = &eff_valid[3:2] && disp_value > sp[2] && disp_value <= sp[3]; // R09 R19
            next_cond[3] = eff_valid[3] && disp_value > sp[3]; // R09 R19
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cond   <= '0;
            eval_d <= 1'b0;
        end else begin
            eval_d <= eval;
            if (eval)
                cond <= next_cond; // R27
        end
    end

    ////////////////////////////////////////////////////////////////
    // per-setpoint delay state machines
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_SP; i++) begin
                st[i]   <= SAE_IDLE; // R28
                dcnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_SP; i++) begin
                case (st[i])
                    SAE_IDLE: begin
                        dcnt[i] <= '0;
                        if (cond[i])
                            st[i] <= SAE_ON_WAIT; // R05
                    end
                    SAE_ON_WAIT: begin
                        if (!cond[i])
                            st[i] <= SAE_IDLE; // R06
                        else if (sae_elapsed(dcnt[i], on_dly[i]))
                            st[i] <= SAE_ACTIVE; // R01 R05
                        else if (tick)
                            dcnt[i] <= dcnt[i] + 1'b1;
                    end
                    SAE_ACTIVE: begin
                        dcnt[i] <= '0;
                        if (!cond[i])
                            st[i] <= (os_time[i] != '0) ? SAE_IDLE : SAE_OFF_WAIT; // R07 R26
                    end
                    SAE_OFF_WAIT: begin
                        if (cond[i])
                            st[i] <= SAE_ACTIVE; // R08
                        else if (sae_elapsed(dcnt[i], off_dly[i]))
                            st[i] <= SAE_IDLE; // R07
                        else if (tick)
                            dcnt[i] <= dcnt[i] + 1'b1;
                    end
                    default: st[i] <= SAE_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // one-shot pulse timers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_SP; i++)
                os_cnt[i] <= '0; // R28
        end else begin
            for (int i = 0; i < NUM_SP; i++) begin
                if (os_time[i] != '0 && cond[i] &&
                    ((st[i] == SAE_ON_WAIT && sae_elapsed(dcnt[i], on_dly[i])) ||
                     (event_mode && eval_d && st[i] == SAE_ACTIVE)))
                    os_cnt[i] <= os_time[i] + 1'b1; // R13 R15
                else if (tick && os_cnt[i] != '0)
                    os_cnt[i] <= os_cnt[i] - 1'b1; // R14
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // indicators, coils and colour
    always_comb begin
        unconf = 1'b0;
        for (int i = 0; i < NUM_SP; i++) begin
            unconf     = unconf || st[i] == SAE_ON_WAIT || st[i] == SAE_OFF_WAIT;
            // zero one-shot time gives a plain contact output
            alarm_c[i] = (os_time[i] == '0) ? ind_c[i] : (os_cnt[i] != '0); // R25
        end
    end

    assign suppress = no_measure || power_on_delay || standby; // R03
    // in zone pattern the band region needs both bounding setpoints
    assign zone_ok  = !pat_zone || &eff_valid[2:1]; // R19

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            trip_ind   <= '0; // R28
            in_band    <= 1'b0;
            coil       <= '0;
            colour_red <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_SP; i++)
                trip_ind[i] <= ind_c[i] || (!event_mode && os_cnt[i] != '0); // R12 R14 R17
            in_band    <= !suppress && zone_ok && (ind_c == '0 || unconf); // R02 R04 R10
            coil       <= alarm_c ^ de_energize; // R16
            colour_red <= (ind_c != '0) ^ colour_sel; // R22
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks
    default clocking sae_cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_ind_after_wait:  assert property ($rose(trip_ind[2]) && os_time[2] == '0 |->
                           $past(st[2], 2) == SAE_ON_WAIT) else $error("indicator rose without on delay"); // R01
    a_band_when_idle:  assert property ($past(rst_n) && !$past(suppress) && $past(ind_c) == '0 && !$past(pat_zone) |->
                           in_band) else $error("in-band missing while idle"); // R02
    a_band_suppress:   assert property (suppress |=> !in_band) else $error("in-band shown while suppressed"); // R03
    a_band_unconf:     assert property (unconf && !suppress && zone_ok |=> in_band)
                           else $error("in-band off during delay"); // R04
    a_on_delay_hold:   assert property (st[2] == SAE_ON_WAIT && dcnt[2] < on_dly[2] |=> st[2] != SAE_ACTIVE)
                           else $error("alarm before on delay elapsed"); // R05
    a_on_abort:        assert property (st[2] == SAE_ON_WAIT && !cond[2] |=> st[2] == SAE_IDLE)
                           else $error("on delay not reset"); // R06
    a_off_resume:      assert property (st[2] == SAE_OFF_WAIT && cond[2] |=> st[2] == SAE_ACTIVE ##1 trip_ind[2])
                           else $error("alarm cancelled during off delay"); // R08
    a_coil_follow:     assert property (ind_c[2] && os_time[2] == '0 ##1 ind_c[2] |->
                           coil[2] == !de_energize[2]) else $error("coil level wrong for alarm"); // R16
    a_type_clear:      assert property (wr_en && paddr == OFF_CTRL &&
                           pwdata[CTRL_TYPE_LO +: TYPE_W] != input_type |=> sp_valid == '0)
                           else $error("setpoints kept after type change"); // R18
    a_pulse_length:    assert property ($rose(os_cnt[2] != '0) |-> (os_cnt[2] != '0) [*8])
                           else $error("one-shot pulse cut short"); // R14

    c_alarm_active:    cover property (st[0] == SAE_ON_WAIT ##1 st[0] == SAE_ACTIVE);
    c_off_resume:      cover property (st[3] == SAE_OFF_WAIT ##1 st[3] == SAE_ACTIVE);
    c_pulse_fired:     cover property ($rose(os_cnt[2] != '0));
    c_zone_alarm:      cover property (pat_zone && trip_ind[1]);

endmodule : sae_evaluator

`default_nettype wire

// ---- bench/sae_meter_model.sv ----
// measurement source model driving display values into the evaluator
`timescale 1ns/1ps
`default_nettype none
module sae_meter_model
    import sae_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   send,
    input  wire logic signed [SP_W-1:0] value,
    output logic signed [SP_W-1:0]      disp_value,
    output logic                        disp_strobe
);
    // value held between strobes: the deadband compare keeps reading it
    always @(posedge core_clk) begin
        disp_strobe <= send;
        if (send) begin
            disp_value <= value;
        end
    end
endmodule : sae_meter_model
`default_nettype wire

// ---- bench/sae_evaluator_tb.sv ----
// self-checking bench for the setpoint alarm evaluator
`timescale 1ns/1ps
`default_nettype none
module sae_evaluator_tb;
    import sae_pkg::*;
    localparam int         TICK  = 10;
    localparam int         SP_H  = 1000;
    localparam logic [7:0] A_VAL = 8'h30;
    localparam logic [7:0] A_CFG = 8'h34;
    localparam logic [7:0] A_DLY = 8'h38;
    localparam logic [7:0] A_OS  = 8'h3C;
    logic                  core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic                  send, samp, disp_strobe, no_measure, power_on_delay, standby, in_band, colour_red;
    logic [7:0]            paddr;
    logic [31:0]           pwdata, prdata, rd;
    logic [3:0]            trip_ind, coil;
    logic signed [23:0]    value, disp_value;
    int                    bad_count, check_count, seed, n, v;

    sae_meter_model src (.core_clk(core_clk), .send(send), .value(value),
                         .disp_value(disp_value), .disp_strobe(disp_strobe));
    sae_evaluator #(.TICK_COUNT(TICK)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .disp_value(disp_value), .disp_strobe(disp_strobe), .sample_input_a(samp),
        .no_measure(no_measure), .power_on_delay(power_on_delay), .standby(standby),
        .trip_ind(trip_ind), .in_band(in_band), .coil(coil), .colour_red(colour_red));

    always #20 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_min(input int got, input int lim);
        check_count++;
        if (got < lim) begin
            bad_count++;
            $display("FAIL t=%0t got=%0h exp=%0h", $time, got, lim);
        end
    endtask : chk_min

    // read data and error are taken at the completing edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        err = pslverr;
        rd  = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic meas(input int x);
        @(posedge core_clk);
        send  <= 1'b1;
        value <= x[23:0];
        @(posedge core_clk);
        send  <= 1'b0;
    endtask : meas

    task automatic settle(input int k);
        repeat (k) @(negedge core_clk);
    endtask : settle

    // bounded wait; n reaches 200 when the level never shows
    task automatic wait_trip(input logic lvl);
        n = 0;
        while (trip_ind[2] !== lvl && n < 200) begin
            @(negedge core_clk);
            n++;
        end
    endtask : wait_trip

    // settled high-trip decision for values well clear of the deadband
    function automatic logic exp_high(input int x);
        return x > SP_H;
    endfunction : exp_high

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        results();
    end

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        {psel, penable, pwrite, send, samp, no_measure, power_on_delay, standby} = 8'h00;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        value = 24'h00_0000;
        bad_count = 0;
        check_count = 0;
        seed = 50548;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        settle(3);
        chk({trip_ind, coil, colour_red}, 16'h0000);
        chk(in_band, 1'b1);
        apb(1'b0, OFF_CTRL, 32'h0);
        chk(rd[0], 1'b0);
        for (int i = 0; i < 3; i++) begin
            @(posedge core_clk);
            {no_measure, power_on_delay, standby} <= 3'b001 << i;
            settle(3);
            chk(in_band, 1'b0);
            @(posedge core_clk);
            {no_measure, power_on_delay, standby} <= 3'b000;
        end
        apb(1'b1, 8'h50, 32'hFFFF_FFFF);
        chk(err, 1'b1);
        apb(1'b1, A_VAL, 32'h8000_0000 | SP_H);
        apb(1'b1, A_DLY, 32'h0003_0003);
        v = SP_H + 100 + ($random(seed) & 255);
        meas(v);
        settle(8);
        chk({trip_ind[2], in_band}, 2'b01);
        wait_trip(1'b1);
        chk_min(n + 8, 3 * TICK);
        settle(2);
        chk({trip_ind, in_band, coil[2], colour_red}, {1'b0, exp_high(v), 2'b00, 3'b011});
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd[4:0], 5'h04);
        v = SP_H - 100 - ($random(seed) & 255);
        meas(v);
        settle(8);
        chk({trip_ind[2], in_band}, 2'b11);
        wait_trip(exp_high(v));
        chk_min(n + 8, 3 * TICK);
        chk(in_band, 1'b1);
        // back above inside the off delay: the alarm must survive
        meas(1500);
        wait_trip(1'b1);
        meas(500);
        settle(6);
        meas(1500);
        settle(60);
        chk(trip_ind[2], 1'b1);
        meas(500);
        wait_trip(1'b0);
        meas(1500);
        settle(6);
        meas(500);
        wait_trip(1'b1);
        chk(n == 200, 1'b1);
        apb(1'b1, A_CFG, 32'h0003_0001);
        settle(3);
        chk(coil[2], 1'b1);
        // one-shot of two counts, no on delay, short excursion
        apb(1'b1, A_DLY, 32'h0003_0000);
        apb(1'b1, A_OS, 32'h0000_0002);
        meas(1500);
        settle(6);
        meas(500);
        settle(2);
        chk({trip_ind[2], coil[2]}, 2'b10);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(rd[12], 1'b0);
        wait_trip(1'b0);
        chk_min(n + 6, 2 * TICK);
        // sample_input_a input mode: only a rising sample_input_a edge evaluates the held value
        apb(1'b1, OFF_CTRL, 32'h0000_0004);
        meas(1500);
        settle(20);
        chk(trip_ind[2], 1'b0);
        @(posedge core_clk) samp <= 1'b1;
        wait_trip(1'b1);
        chk(n < 200, 1'b1);
        meas(500);
        settle(40);
        chk(trip_ind[2], 1'b1);
        @(posedge core_clk) samp <= 1'b0;
        settle(4);
        @(posedge core_clk) samp <= 1'b1;
        wait_trip(1'b0);
        chk(n < 200, 1'b1);
        apb(1'b1, OFF_CTRL, 32'h0000_0010);
        meas(1500);
        wait_trip(1'b1);
        chk(n == 200, 1'b1);
        apb(1'b1, OFF_CTRL, 32'h0000_0011);
        settle(3);
        chk(in_band, 1'b0);
        results();
    end
endmodule : sae_evaluator_tb
`default_nettype wire
